// ### logic/viterbi_traceback_unit.sv
// viterbi traceback datapath with its result buffer
`timescale 1ns/1ps

// ---------------------------------------------
// result word buffer
// ---------------------------------------------
module tb_word_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // all storage of the buffer
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem; // entries
    logic [AW-1:0] wptr; // next write slot
    logic [AW-1:0] rptr; // oldest entry
    logic [AW:0] count; // entries held
  } fifo_type;
  fifo_type st_r;
  fifo_type st_nxt;
  logic push;
  logic pop;

  // honest flags straight from the count
  assign in_ready = st_r.count != (AW+1)'(DEPTH);
  assign out_valid = st_r.count != '0;
  assign out_data = st_r.mem[st_r.rptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // next state: write, read, count
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wptr] = in_data;
      st_nxt.wptr = st_r.wptr + 1'b1;
    end
    if (pop) begin
      st_nxt.rptr = st_r.rptr + 1'b1;
    end
    // simultaneous push and pop keeps count
    if (push && !pop) begin
      st_nxt.count = st_r.count + 1'b1;
    end else if (pop && !push) begin
      st_nxt.count = st_r.count - 1'b1;
    end
  end

  // state register
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // count never passes the depth, or a word would be overwritten
  fifo_bound_a: assert property (
    @(posedge mclk) disable iff (reset)
    st_r.count <= (AW+1)'(DEPTH))
    else $error("buffer count above depth");
endmodule : tb_word_fifo

// ---------------------------------------------
// traceback unit
// ---------------------------------------------
// Contract
// - clear op zeroes both transition registers
// - state 0 at bit 31, descending
// - state from low K-1 bits, rest cleared
// - pick low or high transition bit
// - new state is twice old plus bit
// - memory form writes bit, upper bits zero
// - register form updates decoded bits register
// - pack bit zero: shift left, bit 0
// - pack bit one: shift right, bit 31
// - parallel load also loads low transitions
// - every operation takes one cycle while the result buffer has room; a full buffer stalls every op
// - only set-K alters status flags, via the K field
// - set-K writes 3-bit immediate field
module viterbi_traceback_unit
  import vtb_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic op_valid,
  output logic op_ready,
  input wire logic [15:0] op_lsw,
  input wire logic [15:0] op_msw,
  input wire logic [31:0] op_mem_rdata,
  input wire logic mov_wr_en,
  input wire logic [2:0] mov_wr_sel,
  input wire logic [31:0] mov_wr_data,
  output logic mem_wr_valid,
  input wire logic mem_wr_ready,
  output logic [31:0] mem_wr_data,
  output logic [31:0] transition_bits_low,
  output logic [31:0] transition_bits_high,
  output logic [31:0] traceback_state_reg,
  output logic [31:0] decoded_bits_reg,
  output logic [STATUS_W-1:0] accel_status_reg
);
  // ---------------------------------------------
  // state
  // ---------------------------------------------
  typedef struct packed {
    logic [31:0] low; // transitions, states 0..31
    logic [31:0] high; // transitions, states 32..63
    logic [31:0] trace; // traceback state
    logic [31:0] decoded; // packed decoder output
    logic [2:0] k; // constraint length field
    logic output_packing_bit; // packing direction
  } unit_type;
  unit_type st_r;
  unit_type st_nxt;

  logic fire; // operation accepted
  logic is_clear; // clear-transition op
  logic is_treg; // register-output trace
  logic is_tmem; // memory-output trace
  logic is_tpld; // trace with parallel load
  logic is_setk; // set constraint length
  logic step; // any trace form
  logic [6:0] smask; // K-1 bit state mask
  logic [6:0] s; // current state
  logic [6:0] lo_lim; // 2^(K-2)
  logic [6:0] idx; // transition bit index
  logic dec_bit; // decoded bit
  logic [31:0] mask32; // K-1 bit mask, word wide
  logic [31:0] trace_nxt; // state after step
  logic fifo_in_ready; // buffer has room

  // ---------------------------------------------
  // decode
  // ---------------------------------------------
  // a full buffer stalls every op, which keeps
  // operations in order at the cost of some throughput
  assign op_ready = fifo_in_ready;
  assign fire = op_valid && op_ready;
  assign is_clear = op_lsw == OP_CLEAR_LSW;
  assign is_treg = op_lsw == OP_TRACE_REG_LSW;
  assign is_tmem = (op_lsw == OP_TRACE_MEM_LSW)
    && (op_msw[15:8] == OP_TRACE_MEM_MSW);
  assign is_tpld = (op_lsw == OP_TRACE_PLD_LSW)
    && (op_msw[15:8] == OP_TRACE_PLD_MSW);
  assign is_setk = (op_lsw == OP_SETK_LSW)
    && (op_msw[15:3] == OP_SETK_MSW);
  assign step = is_treg || is_tmem || is_tpld;

  // ---------------------------------------------
  // traceback step datapath
  // ---------------------------------------------
  // K below 3 is not meaningful; the shifts just wrap
  always_comb begin
    smask = (7'h01 << (st_r.k - 3'd1)) - 7'h01;
    s = st_r.trace[6:0] & smask;
    lo_lim = 7'h01 << (st_r.k - 3'd2);
    // descending bit order per register
    if (s < lo_lim) begin
      idx = lo_lim - 7'h01 - s;
      dec_bit = st_r.low[idx[4:0]];
    end else begin
      idx = (lo_lim << 1) - 7'h01 - s;
      dec_bit = st_r.high[idx[4:0]];
    end
    mask32 = (32'h0000_0001 << (st_r.k - 3'd1))
      - 32'h0000_0001;
    // upper bits fall to zero through the mask
    trace_nxt = {25'h000_0000, s[5:0], dec_bit}
      & mask32;
  end

  // ---------------------------------------------
  // next state
  // ---------------------------------------------
  // move port writes first; ops override the same cycle
  always_comb begin
    st_nxt = st_r;
    if (mov_wr_en) begin
      case (mov_wr_sel)
        SEL_LOW: st_nxt.low = mov_wr_data;
        SEL_HIGH: st_nxt.high = mov_wr_data;
        SEL_STATE: st_nxt.trace = mov_wr_data;
        SEL_DECODED: st_nxt.decoded = mov_wr_data;
        SEL_STATUS: begin
          st_nxt.k = mov_wr_data[K_MSB:K_LSB];
          st_nxt.output_packing_bit = mov_wr_data[OUTPUT_PACKING_BIT_BIT];
        end
        default: st_nxt = st_r; // unmapped select
      endcase
    end
    // every op completes in this one cycle
    if (fire) begin
      if (is_clear) begin
        st_nxt.low = WORD_RESET;
        st_nxt.high = WORD_RESET;
      end
      if (is_setk) begin
        st_nxt.k = op_msw[2:0];
      end
      if (step) begin
        // status fields stay untouched here
        st_nxt.trace = trace_nxt;
      end
      if (is_treg || is_tpld) begin
        if (!st_r.output_packing_bit) begin
          st_nxt.decoded = {st_r.decoded[30:0], dec_bit};
        end else begin
          st_nxt.decoded = {dec_bit, st_r.decoded[31:1]};
        end
      end
      // step above read the old low value
      if (is_tpld) begin
        st_nxt.low = op_mem_rdata;
      end
    end
  end

  // state register
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_r <= '{WORD_RESET, WORD_RESET, WORD_RESET,
        WORD_RESET, K_RESET, 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------
  // memory result path
  // ---------------------------------------------
  tb_word_fifo #(
    .W(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .reset(reset),
    .in_valid(op_valid && is_tmem),
    .in_ready(fifo_in_ready),
    .in_data({31'h0000_0000, dec_bit}),
    .out_valid(mem_wr_valid),
    .out_ready(mem_wr_ready),
    .out_data(mem_wr_data)
  );

  // register views
  assign transition_bits_low = st_r.low;
  assign transition_bits_high = st_r.high;
  assign traceback_state_reg = st_r.trace;
  assign decoded_bits_reg = st_r.decoded;
  assign accel_status_reg = {st_r.output_packing_bit, st_r.k};

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  clear_zero_a: assert property (
    @(posedge mclk) disable iff (reset)
    fire && is_clear && !mov_wr_en |=> st_r.low == 0 && st_r.high == 0)
    else $error("clear left transitions nonzero");

  low_pick_a: assert property (
    @(posedge mclk) disable iff (reset)
    fire && step && st_r.k == 3'd7 && st_r.trace[5:0] < 6'd32
    |-> dec_bit == st_r.low[5'd31 - st_r.trace[4:0]])
    else $error("wrong low transition bit");

  high_pick_a: assert property (
    @(posedge mclk) disable iff (reset)
    fire && step && st_r.k == 3'd7 && st_r.trace[5:0] >= 6'd32
    |-> dec_bit == st_r.high[5'd31 - st_r.trace[4:0]])
    else $error("wrong high transition bit");

  state_step_a: assert property (
    @(posedge mclk) disable iff (reset)
    fire && step && !mov_wr_en && st_r.k == 3'd4
    |=> st_r.trace == {29'h0, $past(st_r.trace[1:0]), $past(dec_bit)})
    else $error("state update wrong");

  upper_clear_a: assert property (
    @(posedge mclk) disable iff (reset)
    fire && step && !mov_wr_en && st_r.k == 3'd5
    |=> st_r.trace[31:4] == 28'h0)
    else $error("state upper bits kept");

  mem_word_a: assert property (
    @(posedge mclk) disable iff (reset)
    mem_wr_valid |-> mem_wr_data[31:1] == 31'h0)
    else $error("memory word upper bits set");

  pack_left_a: assert property (
    @(posedge mclk) disable iff (reset)
    fire && is_treg && !st_r.output_packing_bit && !mov_wr_en
    |=> st_r.decoded == {$past(st_r.decoded[30:0]), $past(dec_bit)})
    else $error("left packing wrong");

  pack_right_a: assert property (
    @(posedge mclk) disable iff (reset)
    fire && is_treg && st_r.output_packing_bit && !mov_wr_en
    |=> st_r.decoded == {$past(dec_bit), $past(st_r.decoded[31:1])})
    else $error("right packing wrong");

  par_load_a: assert property (
    @(posedge mclk) disable iff (reset)
    fire && is_tpld |=> st_r.low == $past(op_mem_rdata)
      && st_r.decoded == ($past(st_r.output_packing_bit)
        ? {$past(dec_bit), $past(st_r.decoded[31:1])}
        : {$past(st_r.decoded[30:0]), $past(dec_bit)}))
    else $error("parallel load wrong");

  status_keep_a: assert property (
    @(posedge mclk) disable iff (reset)
    fire && (step || is_clear) && !mov_wr_en |=> $stable(accel_status_reg))
    else $error("status changed by op");

  setk_field_a: assert property (
    @(posedge mclk) disable iff (reset)
    fire && is_setk && !mov_wr_en |=> st_r.k == $past(op_msw[2:0]))
    else $error("constraint length not written");

  // an idle buffer shows the word one cycle after the op
  word_next_a: assert property (
    @(posedge mclk) disable iff (reset)
    fire && is_tmem && !mem_wr_valid
    |=> mem_wr_valid && mem_wr_data == {31'h0000_0000, $past(dec_bit)})
    else $error("memory word late or wrong");

  // register forms never reach the memory side
  reg_no_mem_a: assert property (
    @(posedge mclk) disable iff (reset)
    fire && (is_treg || is_tpld) && !mem_wr_valid
    |=> !mem_wr_valid)
    else $error("register form wrote memory");
endmodule : viterbi_traceback_unit

// ### logic/vtb_pkg.sv
// constants for the viterbi traceback unit
package vtb_pkg;
  // ---------------------------------------------
  // opcode words
  // ---------------------------------------------
  localparam logic [15:0] OP_CLEAR_LSW = 16'hE529;
  localparam logic [15:0] OP_TRACE_REG_LSW = 16'hE528;
  localparam logic [15:0] OP_TRACE_MEM_LSW = 16'hE20C;
  localparam logic [7:0] OP_TRACE_MEM_MSW = 8'h00;
  localparam logic [15:0] OP_TRACE_PLD_LSW = 16'hE2B0;
  localparam logic [7:0] OP_TRACE_PLD_MSW = 8'h01;
  localparam logic [15:0] OP_SETK_LSW = 16'hE6F2;
  localparam logic [12:0] OP_SETK_MSW = 13'h0120;
  // ---------------------------------------------
  // move-port register selects
  // ---------------------------------------------
  localparam logic [2:0] SEL_LOW = 3'h0;
  localparam logic [2:0] SEL_HIGH = 3'h1;
  localparam logic [2:0] SEL_STATE = 3'h2;
  localparam logic [2:0] SEL_DECODED = 3'h3;
  localparam logic [2:0] SEL_STATUS = 3'h4;
  // ---------------------------------------------
  // status fields and reset values
  // ---------------------------------------------
  localparam int K_LSB = 0;
  localparam int K_MSB = 2;
  localparam int OUTPUT_PACKING_BIT_BIT = 3;
  localparam int STATUS_W = 4;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [2:0] K_RESET = 3'h0;
  // ---------------------------------------------
  // output buffer shape
  // ---------------------------------------------
  localparam int FIFO_W = 32;
  localparam int FIFO_DEPTH = 16;
endpackage : vtb_pkg

// ### dv/vtb_mem_sink.sv
// result sink model standing for the data memory side
`timescale 1ns/1ps

// ---------------------------------------------
// memory sink
// ---------------------------------------------
module vtb_mem_sink (
  input wire logic mclk,
  input wire logic reset,
  input wire logic hold,
  input wire logic slow,
  output logic mem_wr_ready
);
  // ready is registered: never a comb path from valid, so no loop
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mem_wr_ready <= 1'b0;
    end else begin
      // hold stalls fully, slow drops ready at random
      mem_wr_ready <= !hold && (!slow || $urandom_range(1, 0) == 1);
    end
  end
endmodule : vtb_mem_sink

// ### dv/viterbi_traceback_unit_bench.sv
// self-checking bench for the viterbi traceback unit
`timescale 1ns/1ps

module viterbi_traceback_unit_bench
  import vtb_pkg::*;
;
  logic mclk, reset, op_valid, op_ready, mov_wr_en, mem_wr_valid, mem_wr_ready, hold, slow;
  logic [15:0] op_lsw, op_msw;
  logic [31:0] op_mem_rdata, mov_wr_data, mem_wr_data, lo, hi, st, dec;
  logic [2:0] mov_wr_sel;
  logic [STATUS_W-1:0] stat;
  // reference model of the registers
  logic [31:0] m_lo, m_hi, m_st, m_dec;
  logic [2:0] m_k;
  logic m_pk;
  logic [31:0] exp_q[$];
  int n_errors, checks_done, n_stall;

  // ---------------------------------------------
  // design and partner
  // ---------------------------------------------
  viterbi_traceback_unit u_dut (.mclk(mclk), .reset(reset), .op_valid(op_valid),
    .op_ready(op_ready), .op_lsw(op_lsw), .op_msw(op_msw), .op_mem_rdata(op_mem_rdata),
    .mov_wr_en(mov_wr_en), .mov_wr_sel(mov_wr_sel), .mov_wr_data(mov_wr_data),
    .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready), .mem_wr_data(mem_wr_data),
    .transition_bits_low(lo), .transition_bits_high(hi), .traceback_state_reg(st),
    .decoded_bits_reg(dec), .accel_status_reg(stat));
  vtb_mem_sink u_sink (.mclk(mclk), .reset(reset), .hold(hold), .slow(slow),
    .mem_wr_ready(mem_wr_ready));

  // 25 MHz clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // ---------------------------------------------
  // tasks
  // ---------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task final_report;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  // one traceback step on the model, returns the decoded bit
  function automatic logic step();
    int kk;
    logic [31:0] s;
    logic [31:0] mask;
    logic b;
    kk = int'(m_k);
    mask = (32'h0000_0001 << (kk - 1)) - 32'h0000_0001;
    s = m_st & mask;
    if (s < (32'h0000_0001 << (kk - 2))) begin
      b = m_lo[(32'h0000_0001 << (kk - 2)) - 1 - s];
    end else begin
      b = m_hi[(32'h0000_0001 << (kk - 1)) - 1 - s];
    end
    m_st = ((s << 1) + 32'(b)) & mask;
    return b;
  endfunction : step

  // request held until taken; strobe left up for back-to-back use
  task op(input logic [15:0] lsw, input logic [15:0] msw, input logic [31:0] mem);
    logic b;
    int i;
    op_valid <= 1'b1;
    mov_wr_en <= 1'b0;
    op_lsw <= lsw;
    op_msw <= msw;
    op_mem_rdata <= mem;
    for (i = 0; i < 200; i++) begin
      @(negedge mclk);
      if (op_ready === 1'b1) break;
      n_stall++;
    end
    if (i == 200) begin
      n_errors++;
      final_report();
    end
    @(posedge mclk);
    // model follows the taken opcode
    if (lsw == OP_CLEAR_LSW) begin
      m_lo = '0;
      m_hi = '0;
    end else if (lsw == OP_TRACE_MEM_LSW && msw[15:8] == OP_TRACE_MEM_MSW) begin
      b = step();
      exp_q.push_back({31'h0, b});
    end else if (lsw == OP_TRACE_REG_LSW
        || (lsw == OP_TRACE_PLD_LSW && msw[15:8] == OP_TRACE_PLD_MSW)) begin
      b = step();
      m_dec = m_pk ? {b, m_dec[31:1]} : {m_dec[30:0], b};
      if (lsw == OP_TRACE_PLD_LSW) m_lo = mem;
    end else if (lsw == OP_SETK_LSW && msw[15:3] == OP_SETK_MSW) begin
      m_k = msw[2:0];
    end
  endtask : op

  // move-port write, one cycle
  task mov(input logic [2:0] sel, input logic [31:0] d);
    mov_wr_en <= 1'b1;
    op_valid <= 1'b0;
    mov_wr_sel <= sel;
    mov_wr_data <= d;
    @(posedge mclk);
    case (sel)
      SEL_LOW: m_lo = d;
      SEL_HIGH: m_hi = d;
      SEL_STATE: m_st = d;
      SEL_DECODED: m_dec = d;
      SEL_STATUS: {m_pk, m_k} = d[3:0];
      default: ; // ignored selects
    endcase
  endtask : mov

  // ---------------------------------------------
  // watcher: registers every cycle, words as they leave
  // ---------------------------------------------
  always @(negedge mclk) begin
    if (reset === 1'b0) begin
      check(lo, m_lo, "low");
      check(hi, m_hi, "high");
      check(st, m_st, "state");
      check(dec, m_dec, "decoded");
      check(32'(stat), 32'({m_pk, m_k}), "status");
      if (mem_wr_valid === 1'b1 && mem_wr_ready === 1'b1) begin
        check(32'(exp_q.size() > 0), 32'h0000_0001, "word due");
        if (exp_q.size() > 0) check(mem_wr_data, exp_q.pop_front(), "word");
      end
    end
  end

  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    int i;
    int kk;
    int s;
    void'($urandom(32'h2017));
    {op_valid, mov_wr_en, hold, slow, reset} = 5'h01;
    {op_lsw, op_msw, op_mem_rdata, mov_wr_sel, mov_wr_data} = '0;
    {m_lo, m_hi, m_st, m_dec, m_k, m_pk} = '0;
    {n_errors, checks_done, n_stall} = '0;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    $display("test reset done");
    mov(SEL_LOW, $urandom());
    mov(SEL_HIGH, $urandom());
    op(OP_CLEAR_LSW, 16'h0000, 32'h0000_0000);
    $display("test clear done");
    // every state index at every usable constraint length
    for (kk = 3; kk < 8; kk++) begin
      mov(SEL_STATUS, 32'(kk));
      mov(SEL_LOW, $urandom());
      mov(SEL_HIGH, $urandom());
      for (s = 0; s < (1 << (kk - 1)); s++) begin
        mov(SEL_STATE, 32'(s));
        op(OP_TRACE_MEM_LSW, {OP_TRACE_MEM_MSW, 8'(s)}, 32'h0000_0000);
      end
    end
    $display("test indexing done");
    slow <= 1'b1;
    mov(SEL_STATE, 32'h0000_0000);
    for (i = 0; i < 400; i++) begin
      case ($urandom_range(7, 0))
        0: op(OP_CLEAR_LSW, 16'h0000, $urandom());
        1: op(OP_TRACE_REG_LSW, 16'h0000, $urandom());
        2: op(OP_TRACE_MEM_LSW, {OP_TRACE_MEM_MSW, 8'($urandom())}, $urandom());
        3: op(OP_TRACE_PLD_LSW, {OP_TRACE_PLD_MSW, 8'($urandom())}, $urandom());
        4: op(OP_SETK_LSW, {OP_SETK_MSW, 3'($urandom_range(7, 3))}, $urandom());
        5: mov(SEL_STATUS, 32'({1'($urandom()), 3'($urandom_range(7, 3))}));
        6: mov(3'($urandom_range(3, 0)), $urandom());
        default: begin
          mov(3'($urandom_range(7, 5)), $urandom());
          op(16'hFFFF, 16'hFFFF, $urandom());
        end
      endcase
    end
    $display("test random done");
    // sink stalls until the buffer refuses, then drains
    slow <= 1'b0;
    hold <= 1'b1;
    n_stall = 0;
    fork
      begin
        repeat (60) @(posedge mclk);
        hold <= 1'b0;
      end
    join_none
    for (i = 0; i < FIFO_DEPTH + 4; i++) op(OP_TRACE_MEM_LSW, 16'h0000, 32'h0000_0000);
    op_valid <= 1'b0;
    check(32'(n_stall > 0), 32'h0000_0001, "refused");
    for (i = 0; i < 200 && exp_q.size() > 0; i++) @(posedge mclk);
    check(32'(exp_q.size()), 32'h0000_0000, "drained");
    $display("test full done");
    final_report();
  end
endmodule : viterbi_traceback_unit_bench
